// ==== hdl/blfs_pkg.sv ====
// package: constants, states and carrier structs of the boost led fault sequencer
package blfs_pkg;

    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned STANDBY_MS      = 20;
    localparam int unsigned COMP_HIGH_MS    = 37;
    localparam int unsigned MIN_ON_NS       = 600;
    localparam int unsigned SW_FREQ_HZ      = 120_000;
    localparam int unsigned CS_HIGH_CYCLES  = 17;
    localparam int unsigned SS_STEPS        = 1024;
    localparam int unsigned REF_WIDTH       = 10;
    // longest times round down, least times round up
    localparam int unsigned STANDBY_CYC     = STANDBY_MS * (CLK_HZ / 1000);
    localparam int unsigned COMP_HIGH_CYC   = COMP_HIGH_MS * (CLK_HZ / 1000);
    localparam int unsigned MIN_ON_CYC      = (MIN_ON_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SW_PERIOD_CYC   = CLK_HZ / SW_FREQ_HZ;
    localparam int unsigned MAX_DUTY_PCT    = 95;
    localparam int unsigned MAX_ON_CYC      = SW_PERIOD_CYC * MAX_DUTY_PCT / 100;

    typedef enum logic [3:0] {
        ST_STANDBY = 4'h1,
        ST_CHECK   = 4'h2,
        ST_RUN     = 4'h4,
        ST_LATCHED = 4'h8
    } blfs_state_e;

    typedef struct packed {
        logic supply_good;       // supply_in above rising threshold, low below falling
        logic out_sense_short0;  // out_sense below start-up short level
        logic out_sense_short1;  // out_sense below run-time short level
        logic out_over;          // out_sense above overvoltage level
        logic cs_high;           // switch current above high-current level
        logic comp_high;         // error_amp output above high level
        logic fb_high;           // led_feedback high fault
        logic overcurrent_limit; // peak switch current at overcurrent_limit
        logic over_temp;         // junction above limit
        logic peak_reached;      // current plus slope reached error_amp level
        logic skip_request;      // light load, one minimum pulse per cycle
    } blfs_sense_s;

    typedef struct packed {
        logic out_over;
        logic comp_high;
        logic cs_high;
        logic out_short;
        logic over_temp;
    } blfs_fault_s;

endpackage

// ==== hdl/blfs_sequencer.sv ====
// boost led fault sequencer: enable, start-up check, lockout, pulse control and latched faults
//
// Notes on behaviour
// - the first rising edge on the dimming input wakes the block at once and toggling keeps it awake.
// - standby is entered only after the dimming input stays low for the full standby timeout, or when supply_good falls.
// - on wake the out_sense start-up short comparator is checked and switching stays off if it is set.
// - soft-start switching begins only when no lockout, current, comp, feedback, overcurrent or thermal fault.
// - the block stays off until supply_good rises and turns off when it falls (hysteresis is analog).
// - outside skip mode each on-time ends, no sooner than the minimum on-time, when sensed current plus slope reaches the error_amp level, or at the maximum duty.
// - at light load no pulse is skipped: every cycle fires one pulse lasting the fixed minimum on-time.
// - an internal square wave follows the dimming duty and is filtered into the feedback reference.
// - an out_sense overvoltage trip latches switching off until supply or dimming reset.
// - comp high held without a break for the full timeout latches the drive off.
// - switch current high on the set number of consecutive cycles latches the drive off.
// - in normal running an out_sense run-time short latches the drive off.
// - overtemperature latches the controller and current sources off.
`timescale 1ns/1ps
module blfs_sequencer #(
    parameter int unsigned STANDBY_CYCLES   = blfs_pkg::STANDBY_CYC,
    parameter int unsigned COMP_HIGH_CYCLES = blfs_pkg::COMP_HIGH_CYC,
    parameter int unsigned CS_HIGH_LIMIT    = blfs_pkg::CS_HIGH_CYCLES,
    parameter int unsigned REF_W            = blfs_pkg::REF_WIDTH
) (
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               dim_in,
    input  wire blfs_pkg::blfs_sense_s sense,
    output logic                    gate_drive,
    output logic                    active,
    output logic                    current_src_en,
    output logic [REF_W-1:0]        fb_reference,
    output logic [REF_W-1:0]        soft_start_level,
    output blfs_pkg::blfs_fault_s   fault_latched
);
    import blfs_pkg::*;

    localparam int unsigned SBW = $clog2(STANDBY_CYCLES + 1);
    localparam int unsigned CHW = $clog2(COMP_HIGH_CYCLES + 1);
    localparam int unsigned CSW = $clog2(CS_HIGH_LIMIT + 1);
    localparam int unsigned SWW = $clog2(SW_PERIOD_CYC + 1);

    logic                dim_q;
    logic [SBW-1:0]      low_cnt_q;
    logic                standby_hit;
    blfs_state_e         state_q;
    blfs_state_e         state_d;
    logic                any_latch;
    logic                start_ok;
    logic [SWW-1:0]      sw_cnt_q;
    logic                cycle_start;
    logic                gate_q;
    logic [SWW-1:0]      on_cnt_q;
    logic [CHW-1:0]      comp_cnt_q;
    logic [CSW-1:0]      cs_cnt_q;
    logic                cs_seen_q;
    logic [REF_W-1:0]    ref_q;
    logic [REF_W-1:0]    ss_q;
    blfs_fault_s         fault_q;
    logic                clear_faults;

    ////////////////////////////////////////////////////////////////////////
    // dimming input: wake on rising edge, standby after long low
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dim_q <= 1'b0;
        end else begin
            dim_q <= dim_in;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            low_cnt_q <= '0;
        end else if (dim_in) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != SBW'(STANDBY_CYCLES)) begin
            low_cnt_q <= low_cnt_q + SBW'(1);
        end
    end

    assign standby_hit  = !dim_in && (low_cnt_q == SBW'(STANDBY_CYCLES - 1));
    assign clear_faults = !sense.supply_good || standby_hit;
    assign any_latch    = |fault_q;
    assign start_ok     = sense.supply_good && !sense.cs_high && !sense.comp_high && !sense.fb_high
                          && !sense.overcurrent_limit && !sense.over_temp;

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_STANDBY: begin
                if (dim_in && !dim_q && sense.supply_good) begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (clear_faults) begin
                    state_d = ST_STANDBY;
                end else if (!sense.out_sense_short0 && start_ok) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (clear_faults) begin
                    state_d = ST_STANDBY;
                end else if (any_latch) begin
                    state_d = ST_LATCHED;
                end
            end
            ST_LATCHED: begin
                if (clear_faults) begin
                    state_d = ST_STANDBY;
                end
            end
            default: state_d = ST_STANDBY;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_STANDBY;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched faults; a clear condition also holds the latches empty
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_q <= '0;
        end else if (clear_faults) begin
            fault_q <= '0;
        end else if (state_q == ST_RUN) begin
            if (sense.out_over)
                fault_q.out_over <= 1'b1;
            if (comp_cnt_q == CHW'(COMP_HIGH_CYCLES - 1) && sense.comp_high)
                fault_q.comp_high <= 1'b1;
            if (cycle_start && cs_cnt_q == CSW'(CS_HIGH_LIMIT - 1) && cs_seen_q)
                fault_q.cs_high <= 1'b1;
            if (sense.out_sense_short1)
                fault_q.out_short <= 1'b1;
            if (sense.over_temp)
                fault_q.over_temp <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            comp_cnt_q <= '0;
        end else if (!sense.comp_high || state_q != ST_RUN) begin
            comp_cnt_q <= '0;
        end else if (comp_cnt_q != CHW'(COMP_HIGH_CYCLES - 1)) begin
            comp_cnt_q <= comp_cnt_q + CHW'(1);
        end
    end

    // current high caught at any point of a switching cycle and counted once per cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_seen_q <= 1'b0;
            cs_cnt_q  <= '0;
        end else if (state_q != ST_RUN) begin
            cs_seen_q <= 1'b0;
            cs_cnt_q  <= '0;
        end else if (cycle_start) begin
            cs_seen_q <= sense.cs_high;
            cs_cnt_q  <= cs_seen_q ? ((cs_cnt_q == CSW'(CS_HIGH_LIMIT)) ? cs_cnt_q : cs_cnt_q + CSW'(1))
                                   : '0;
        end else if (sense.cs_high) begin
            cs_seen_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fixed-frequency gate drive with peak current end and minimum pulse at light load
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_cnt_q <= '0;
        end else if (sw_cnt_q == SWW'(SW_PERIOD_CYC - 1)) begin
            sw_cnt_q <= '0;
        end else begin
            sw_cnt_q <= sw_cnt_q + SWW'(1);
        end
    end

    assign cycle_start = (sw_cnt_q == SWW'(SW_PERIOD_CYC - 1));

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_q   <= 1'b0;
            on_cnt_q <= '0;
        end else if (state_q != ST_RUN || any_latch || clear_faults) begin
            gate_q   <= 1'b0;
            on_cnt_q <= '0;
        end else if (cycle_start) begin
            gate_q   <= 1'b1;
            on_cnt_q <= '0;
        end else if (gate_q) begin
            on_cnt_q <= on_cnt_q + SWW'(1);
            if (sense.skip_request && on_cnt_q == SWW'(MIN_ON_CYC - 1))
                gate_q <= 1'b0;
            else if (!sense.skip_request && on_cnt_q >= SWW'(MIN_ON_CYC - 1) && sense.peak_reached)
                gate_q <= 1'b0;
            else if (on_cnt_q == SWW'(MAX_ON_CYC - 1))
                gate_q <= 1'b0;
        end
    end

    // skip mode still fires one minimum pulse per cycle, so the drive is the register itself
    assign gate_drive = gate_q;

    ////////////////////////////////////////////////////////////////////////
    // duty-following reference: first-order filter of the dimming square wave
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_q <= '0;
        end else if (dim_in) begin
            ref_q <= ref_q + REF_W'(((REF_W+1)'({REF_W{1'b1}}) - (REF_W+1)'(ref_q)) >> 6);
        end else begin
            ref_q <= ref_q - (ref_q >> 6);
        end
    end

    // soft start ramps the reference limit from zero on each start
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ss_q <= '0;
        end else if (state_q != ST_RUN) begin
            ss_q <= '0;
        end else if (cycle_start && ss_q != {REF_W{1'b1}}) begin
            ss_q <= ss_q + REF_W'(1);
        end
    end

    assign fb_reference     = (ref_q < ss_q) ? ref_q : ss_q;
    assign soft_start_level = ss_q;
    assign active           = (state_q != ST_STANDBY);
    assign current_src_en   = (state_q == ST_RUN);
    assign fault_latched    = fault_q;

endmodule // blfs_sequencer

// ==== sim/blfs_assertions.sv ====
// checker: port-level properties of the fault sequencer
`timescale 1ns/1ps
module blfs_checker #(
    parameter int unsigned STANDBY_CYCLES   = 50,
    parameter int unsigned COMP_HIGH_CYCLES = 60,
    parameter int unsigned REF_W            = 10
) (
    input wire logic                  mclk,
    input wire logic                  sys_rst,
    input wire logic                  dim_in,
    input wire blfs_pkg::blfs_sense_s sense,
    input wire logic                  gate_drive,
    input wire logic                  active,
    input wire logic                  current_src_en,
    input wire logic [REF_W-1:0]      fb_reference,
    input wire logic [REF_W-1:0]      soft_start_level,
    input wire blfs_pkg::blfs_fault_s fault_latched
);
    import blfs_pkg::*;
    int unsigned low_q;
    int unsigned on_q;
    int unsigned comp_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) comp_q <= 0;
        else comp_q <= (sense.comp_high && current_src_en) ? comp_q + 1 : 0;
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) low_q <= 0;
        else low_q <= dim_in ? 0 : low_q + 1;
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) on_q <= 0;
        else on_q <= gate_drive ? on_q + 1 : 0;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    property p_wake;
        !active && dim_in && !$past(dim_in) && sense.supply_good |=> active;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on dim rise");
    property p_stay;
        low_q == STANDBY_CYCLES |-> !active;
    endproperty
    a_stay: assert property (p_stay) else $error("no standby after long low");
    property p_early;
        $fell(active) && $past(sense.supply_good) |-> low_q >= STANDBY_CYCLES;
    endproperty
    a_early: assert property (p_early) else $error("standby too early");
    property p_start;
        $rose(current_src_en) |-> !$past(sense.out_sense_short0) && !$past(sense.fb_high);
    endproperty
    a_start: assert property (p_start) else $error("run despite start fault");
    property p_off;
        fault_latched != 5'h00 |=> !gate_drive && !current_src_en;
    endproperty
    a_off: assert property (p_off) else $error("drive on while latched");
    property p_ovp;
        current_src_en && sense.out_over |-> ##[1:3] fault_latched.out_over;
    endproperty
    a_ovp: assert property (p_ovp) else $error("overvoltage not latched");
    property p_cs;
        $rose(fault_latched.cs_high) |-> $past(sense.cs_high);
    endproperty
    a_cs: assert property (p_cs) else $error("current latch without cause");
    property p_min_on;
        $fell(gate_drive) && fault_latched == 5'h00 && active |-> on_q >= MIN_ON_CYC;
    endproperty
    a_min_on: assert property (p_min_on) else $error("pulse below minimum");
    property p_peak;
        gate_drive && sense.peak_reached && on_q > MIN_ON_CYC |-> ##[1:2] !gate_drive;
    endproperty
    a_peak: assert property (p_peak) else $error("pulse past peak");
    // a high dimming level only pushes the filtered reference up
    property p_ref;
        dim_in && current_src_en |=> fb_reference >= $past(fb_reference);
    endproperty
    a_ref: assert property (p_ref) else $error("reference fell while dim high");
    property p_comp;
        comp_q == COMP_HIGH_CYCLES |-> fault_latched.comp_high;
    endproperty
    a_comp: assert property (p_comp) else $error("comp high not latched");
    c_run: cover property ($rose(current_src_en));
    c_cs: cover property ($rose(fault_latched.cs_high));
    c_sby: cover property ($fell(active));
endmodule // blfs_checker

// ==== sim/blfs_stage_model.sv ====
// boost power stage model: comparator flags seen by the sequencer
`timescale 1ns/1ps
module blfs_stage_model (
    input  wire logic                  mclk,
    input  wire logic                  gate_drive,
    input  wire logic [31:0]           peak_dly,
    input  wire blfs_pkg::blfs_sense_s inj,
    output blfs_pkg::blfs_sense_s      sense
);
    import blfs_pkg::*;
    int unsigned on_q;
    always_ff @(posedge mclk) on_q <= gate_drive ? on_q + 1 : 0;
    // inductor current ramps only while the switch conducts
    always_comb begin
        sense = inj;
        sense.peak_reached = gate_drive && on_q >= peak_dly;
    end
endmodule // blfs_stage_model

// ==== sim/blfs_sequencer_tb.sv ====
// testbench: wake, standby, start check, pulses and latched faults
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module blfs_sequencer_tb;
    import blfs_pkg::*;
    localparam int SBY   = 50;
    logic        mclk    = 1'b0;
    logic        sys_rst = 1'b1;
    logic        dim_in  = 1'b0;
    blfs_sense_s inj     = '0;
    logic [31:0] dly     = 32'h0000_001E;
    blfs_sense_s sense;
    logic        gate_drive, active, current_src_en;
    logic [9:0]  fb_reference, soft_start_level;
    blfs_fault_s fault_latched;
    int          errors = 0, tests_run = 0, n, w;
    int          src[5] = '{2, 8, 6, 5, 7};
    int          m_low  = 0;
    logic        m_dq   = 1'b0;
    logic        m_act  = 1'b0;
    wire [7:0]   watch = {fault_latched, gate_drive, current_src_en, active};
    always #12.5 mclk = ~mclk;
    // model of the awake flag: wake on a dim rise, sleep after a long low or on lockout
    always @(posedge mclk) begin
        if (sys_rst) begin
            m_low <= 0;
            m_dq  <= 1'b0;
            m_act <= 1'b0;
        end else begin
            `CHK(active, m_act)
            if (!m_act && dim_in && !m_dq && inj.supply_good) m_act <= 1'b1;
            else if (!inj.supply_good || (!dim_in && m_low == SBY - 1)) m_act <= 1'b0;
            m_low <= dim_in ? 0 : m_low + 1;
            m_dq  <= dim_in;
        end
    end
    blfs_sequencer #(.STANDBY_CYCLES(SBY), .COMP_HIGH_CYCLES(60)) blfs_sequencer_i (
        .mclk(mclk), .sys_rst(sys_rst), .dim_in(dim_in), .sense(sense),
        .gate_drive(gate_drive), .active(active), .current_src_en(current_src_en),
        .fb_reference(fb_reference), .soft_start_level(soft_start_level),
        .fault_latched(fault_latched));
    blfs_stage_model blfs_stage_model_i (.mclk(mclk), .gate_drive(gate_drive),
        .peak_dly(dly), .inj(inj), .sense(sense));
    ////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // a spent bound counts as a mismatch
    task automatic wait_for(input int k, input logic v, input int lim);
        n = 0;
        while (watch[k] !== v && n < lim) begin
            @(posedge mclk);
            #1 n++;
        end
        if (n >= lim) begin
            errors++;
            finish_test();
        end
    endtask
    task automatic wake;
        @(posedge mclk);
        dim_in <= 1'b1;
        @(posedge mclk);
        #1 `CHK(active, 1'b1)
    endtask
    task automatic pulse;
        wait_for(2, 1'b1, 400);
        w = 0;
        while (gate_drive === 1'b1 && w < 400) begin
            @(posedge mclk);
            #1 w++;
        end
        if (w >= 400) begin
            errors++;
            finish_test();
        end
    endtask
    initial begin
        n = $urandom(4706);
        inj.supply_good = 1'b1;
        inj.out_sense_short0 = 1'b1;
        inj.fb_high = 1'b1;
        repeat (2) @(posedge mclk);
        #1 `CHK(watch, 8'h00)
        @(posedge mclk);
        sys_rst <= 1'b0;
        wake();
        repeat (20) @(posedge mclk);
        inj.out_sense_short0 <= 1'b0;
        repeat (20) @(posedge mclk);
        #1 `CHK(current_src_en, 1'b0)
        @(posedge mclk);
        inj.fb_high <= 1'b0;
        wait_for(1, 1'b1, 5);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            dly <= (i == 3) ? 32'd200 : 32'd30 + ($urandom % 60);
            inj.skip_request <= (i == 3);
            pulse();
            if (i == 3) `CHK(w, MIN_ON_CYC)
            else `CHK(w >= dly && w <= dly + 3, 1'b1)
        end
        `CHK(fb_reference, soft_start_level)
        `CHK(soft_start_level != 10'h000, 1'b1)
        // dimming edges kept faster than the shortened standby count
        repeat (6) begin
            @(posedge mclk);
            dim_in <= ~dim_in;
            repeat (10 + $urandom % 30) @(posedge mclk);
        end
        #1 `CHK(active, 1'b1)
        @(posedge mclk);
        dim_in <= 1'b0;
        repeat (45) @(posedge mclk);
        #1 `CHK(active, 1'b1)
        wait_for(0, 1'b0, 10);
        for (int k = 0; k < 5; k++) begin
            wake();
            wait_for(1, 1'b1, 5);
            @(posedge mclk);
            inj[src[k]] <= 1'b1;
            wait_for(k + 3, 1'b1, 8000);
            @(posedge mclk);
            #1 `CHK(gate_drive, 1'b0)
            @(posedge mclk);
            inj[src[k]] <= 1'b0;
            inj.supply_good <= 1'b0;
            dim_in <= 1'b0;
            wait_for(0, 1'b0, 5);
            #1 `CHK(fault_latched, 5'h00)
            @(posedge mclk);
            inj.supply_good <= 1'b1;
        end
        finish_test();
    end
endmodule // blfs_sequencer_tb
bind blfs_sequencer blfs_checker #(.STANDBY_CYCLES(STANDBY_CYCLES), .COMP_HIGH_CYCLES(COMP_HIGH_CYCLES),
    .REF_W(REF_W)) blfs_checker_i (.mclk(mclk), .sys_rst(sys_rst), .dim_in(dim_in), .sense(sense),
    .gate_drive(gate_drive), .active(active), .current_src_en(current_src_en),
    .fb_reference(fb_reference), .soft_start_level(soft_start_level), .fault_latched(fault_latched));
